// [verilog/pcr_cfg.svh]
// Purpose: Constants for the parallel configuration loader.
// Assumes: 20 MHz system clock, AXI4-Lite register access.
// Notes: Offsets are byte addresses of 32-bit registers.
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

`define PCR_ADDR_W        8
`define PCR_OFF_CTRL      8'h00
`define PCR_OFF_STATUS    8'h04
`define PCR_OFF_WORDS     8'h08
`define PCR_OFF_DATA      8'h0c
`define PCR_OFF_PERIOD    8'h10
`define PCR_CTRL_W_LO     0
`define PCR_CTRL_DECOMP   2
`define PCR_CTRL_SECURE   3
`define PCR_CTRL_USRCLK   4
`define PCR_CTRL_RST      5'h00
`define PCR_SWITCH_PERIODS 4
`define PCR_USER_PERIODS  8576
`define PCR_PERIOD_W      16
`define PCR_CNT_W         24
`define PCR_RESP_OKAY     2'h0
`define PCR_RESP_SLVERR   2'h2

`endif

// [verilog/pcr_pkg.sv]
// Purpose: Types shared by the parallel configuration loader.
// Assumes: Constants come from pcr_cfg.svh.
// Notes: Types only.
package pcr_pkg;
	// Data bus width choice
	typedef enum logic [1:0] {
		PCR_W8  = 2'h0,
		PCR_W16 = 2'h1,
		PCR_W32 = 2'h2
	} pcr_width_e;

	// Load settings written by software
	typedef struct packed {
		logic       user_clk_on;
		logic       secure;
		logic       decomp;
		pcr_width_e width;
	} pcr_ctrl_s;

	// Initialisation sequence states
	typedef enum logic [3:0] {
		PCR_LOAD   = 4'b0001,
		PCR_SWITCH = 4'b0010,
		PCR_INIT   = 4'b0100,
		PCR_USER   = 4'b1000
	} pcr_phase_e;
endpackage

// [verilog/pcr_sync.sv]
// Purpose: Two-flop synchroniser with edge detect on the stable side.
// Assumes: One clock; input from another domain.
// Notes: Stage one feeds only stage two.
`timescale 1ns/100ps
module pcr_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out,
	output logic      [W-1:0] rise
);
	// All state in one struct
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} pcr_sync_s;

	pcr_sync_s q, d;

	// Shift chain; s3 only serves edge detect
	always_comb begin
		d    = q;
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	// Register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;
	assign rise     = q.s2 & ~q.s3;
endmodule

// [verilog/pcr_ratio.sv]
// Purpose: Clock-to-data ratio lookup for the parallel load.
// Assumes: Settings are stable during a load.
// Notes: Pure combinational table.
`timescale 1ns/100ps
module pcr_ratio (
	input  wire pcr_pkg::pcr_ctrl_s ctrl,
	output logic [3:0]              ratio
);
	// Ratio per width, decompression and security
	function automatic logic [3:0] pcr_lookup(input pcr_pkg::pcr_ctrl_s c);
		logic [3:0] r;
		r = 4'h1;
		unique case (c.width)
			pcr_pkg::PCR_W8: begin
				r = c.decomp ? 4'h2 : 4'h1; // RULE4
			end
			pcr_pkg::PCR_W16: begin
				r = c.decomp ? 4'h4 : (c.secure ? 4'h2 : 4'h1); // RULE3
			end
			pcr_pkg::PCR_W32: begin
				r = c.decomp ? 4'h8 : (c.secure ? 4'h4 : 4'h1); // RULE4
			end
			default: begin
				r = 4'h1; // Illegal width code treated as 1
			end
		endcase
		return r;
	endfunction

	assign ratio = pcr_lookup(ctrl);
endmodule

// [verilog/pcr_loader.sv]
// Purpose: Receiving side of a fast parallel configuration load.
// Assumes: Host drives config_load_clock and data; user_init_clock is a pin.
// Notes: Registers reached over AXI4-Lite; all outputs are registered.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "pcr_cfg.svh"

// Notes on behaviour
// RULE1 - Host clocks r times the word rate
// RULE2 - Extra clock cycles serve decrypt and decompress
// RULE3 - Sixteen bit: ratio 1, 2 or 4
// RULE4 - Eight bit 1/2; thirty-two bit 1/4/8
// RULE5 - Switch clock after four longest load periods
// RULE6 - User mode after switch plus 8576 user periods
// RULE7 - Sample one word per r clocks
module pcr_loader (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [`PCR_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`PCR_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    config_load_clock,
	input  wire logic [31:0]             config_data,
	input  wire logic                    load_complete_flag,
	input  wire logic                    user_init_clock,
	output logic [31:0]                  word_data,
	output logic                         word_valid,
	output logic                         work_cycle,
	output logic                         init_clock_sel,
	output logic                         user_mode
);
	// All module state
	typedef struct packed {
		logic                      awready;
		logic                      wready;
		logic                      aw_got;
		logic                      w_got;
		logic [`PCR_ADDR_W-1:0]    awaddr;
		logic [31:0]               wdata;
		logic [3:0]                wstrb;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      arready;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
		pcr_pkg::pcr_ctrl_s        ctrl;
		logic [3:0]                phase_cnt;
		logic [31:0]               word_data;
		logic                      word_valid;
		logic                      work_cycle;
		logic [31:0]               words;
		logic [`PCR_PERIOD_W-1:0]  per_cnt;
		logic [`PCR_PERIOD_W-1:0]  per_max;
		logic [`PCR_CNT_W-1:0]     wait_cnt;
		pcr_pkg::pcr_phase_e       phase;
		logic                      clk_sel;
		logic                      user_mode;
	} pcr_state_s;

	pcr_state_s q, d;

	logic                         lclk_lvl;   // Synchronised load clock
	logic                         lclk_rise;  // One-cycle load clock edge
	logic [31:0]                  data_s;     // Synchronised data lines
	logic                         done_lvl;   // Synchronised done flag
	logic                         done_rise;  // Done flag edge
	logic                         uclk_rise;  // User clock edge
	logic [3:0]                   ratio;      // Clocks per data word
	logic                         aw_fire;
	logic                         w_fire;
	logic                         ar_fire;
	logic [`PCR_PERIOD_W+1:0]     switch_need; // Two spare bits: four periods never wrap

	// Pins cross into aclk through two flops each
	pcr_sync #(.W(1)) u_lclk_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (config_load_clock),
		.sync_out (lclk_lvl),
		.rise     (lclk_rise)
	);

	// Data lines; a stable word is assumed around the clock edge
	pcr_sync #(.W(32)) u_data_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (config_data),
		.sync_out (data_s),
		.rise     ()
	);

	pcr_sync #(.W(1)) u_done_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (load_complete_flag),
		.sync_out (done_lvl),
		.rise     (done_rise)
	);

	pcr_sync #(.W(1)) u_uclk_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (user_init_clock),
		.sync_out (),
		.rise     (uclk_rise)
	);

	// Ratio from software settings
	pcr_ratio u_ratio (
		.ctrl  (q.ctrl),
		.ratio (ratio)
	);

	assign aw_fire     = s_axi_awvalid & q.awready;
	assign w_fire      = s_axi_wvalid & q.wready;
	assign ar_fire     = s_axi_arvalid & q.arready;
	// Four longest periods in aclk cycles; widened so a saturated period still waits long
	assign switch_need = (`PCR_PERIOD_W+2)'(q.per_max)
			   * (`PCR_PERIOD_W+2)'(`PCR_SWITCH_PERIODS); // RULE5

	// Read mux, decoded once
	function automatic logic [32:0] pcr_read(input logic [`PCR_ADDR_W-1:0] a,
						 input pcr_state_s s);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			`PCR_OFF_CTRL:   r = {1'b0, 27'h0, s.ctrl};
			`PCR_OFF_STATUS: r = {1'b0, 24'h0, s.phase, 1'b0, s.user_mode,
					      s.clk_sel, done_lvl};
			`PCR_OFF_WORDS:  r = {1'b0, s.words};
			`PCR_OFF_DATA:   r = {1'b0, s.word_data};
			`PCR_OFF_PERIOD: r = {1'b0, 16'h0, s.per_max};
			default:         r = {1'b1, 32'h0000_0000}; // Unmapped: error
		endcase
		return r;
	endfunction

	// Next state
	always_comb begin
		logic [32:0] rd;
		rd = 33'h0;
		d  = q;
		d.word_valid = 1'b0;
		d.work_cycle = 1'b0;

		// Write address and data accepted in either order
		if (aw_fire) begin
			d.awready = 1'b0;
			d.aw_got  = 1'b1;
			d.awaddr  = s_axi_awaddr;
		end
		if (w_fire) begin
			d.wready = 1'b0;
			d.w_got  = 1'b1;
			d.wdata  = s_axi_wdata;
			d.wstrb  = s_axi_wstrb;
		end
		// Both halves held: perform the write and answer
		if (q.aw_got && q.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = `PCR_RESP_OKAY;
			if (q.awaddr == `PCR_OFF_CTRL) begin
				if (q.wstrb[0]) begin
					d.ctrl = pcr_pkg::pcr_ctrl_s'(q.wdata[4:0]);
				end
			end else if (q.awaddr == `PCR_OFF_WORDS) begin
				d.words = 32'h0000_0000; // Any write clears the counter unless a word is sampled in the same cycle
			end else begin
				d.bresp = `PCR_RESP_SLVERR; // Read-only or unmapped
			end
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid  = 1'b0;
			d.awready = 1'b1;
			d.wready  = 1'b1;
		end

		// Read: one at a time
		if (ar_fire) begin
			rd        = pcr_read(s_axi_araddr, q);
			d.arready = 1'b0;
			d.rvalid  = 1'b1;
			d.rdata   = rd[31:0];
			d.rresp   = rd[32] ? `PCR_RESP_SLVERR : `PCR_RESP_OKAY;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid  = 1'b0;
			d.arready = 1'b1;
		end

		// Measure the longest load clock period seen, in aclk cycles
		if (lclk_rise) begin
			d.per_cnt = `PCR_PERIOD_W'(1); // Edge cycle counts, so a period reads in full
			if (q.per_cnt > q.per_max) begin
				d.per_max = q.per_cnt;
			end
		end else if (q.per_cnt != '1 && q.phase == pcr_pkg::PCR_LOAD) begin
			d.per_cnt = q.per_cnt + 1'b1;
		end

		// Word framing on load clock edges
		unique case (q.phase)
			pcr_pkg::PCR_LOAD: begin
				if (lclk_rise) begin
					if (q.phase_cnt == 4'h0) begin
						d.word_data  = data_s; // RULE7
						d.word_valid = 1'b1;
						d.words      = q.words + 1'b1;
					end else begin
						d.work_cycle = 1'b1; // RULE2
					end
					// Host keeps r clocks per word
					if (q.phase_cnt + 4'h1 >= ratio) begin // RULE1
						d.phase_cnt = 4'h0;
					end else begin
						d.phase_cnt = q.phase_cnt + 4'h1; // RULE7
					end
				end
				if (done_rise) begin
					d.phase    = pcr_pkg::PCR_SWITCH;
					d.wait_cnt = '0;
				end
			end
			pcr_pkg::PCR_SWITCH: begin
				// Hold off the clock switch, counted in aclk cycles
				d.wait_cnt = q.wait_cnt + 1'b1;
				if (q.wait_cnt >= `PCR_CNT_W'(switch_need)) begin // RULE5
					d.wait_cnt = '0;
					if (q.ctrl.user_clk_on) begin
						d.clk_sel = 1'b1;
						d.phase   = pcr_pkg::PCR_INIT;
					end else begin
						d.phase     = pcr_pkg::PCR_USER;
						d.user_mode = 1'b1;
					end
				end
			end
			pcr_pkg::PCR_INIT: begin
				// Count user clock periods after the switch
				if (uclk_rise) begin
					d.wait_cnt = q.wait_cnt + 1'b1;
				end
				if (q.wait_cnt >= `PCR_CNT_W'(`PCR_USER_PERIODS)) begin // RULE6
					d.phase     = pcr_pkg::PCR_USER;
					d.user_mode = 1'b1;
				end
			end
			pcr_pkg::PCR_USER: begin
				// Done low restarts a new load
				if (!done_lvl) begin
					d.phase     = pcr_pkg::PCR_LOAD;
					d.user_mode = 1'b0;
					d.clk_sel   = 1'b0;
					d.phase_cnt = 4'h0;
					d.per_max   = '0;
				end
			end
			default: begin
				d.phase = pcr_pkg::PCR_LOAD;
			end
		endcase
	end

	// Register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
			q.ctrl    <= pcr_pkg::pcr_ctrl_s'(`PCR_CTRL_RST);
			q.phase   <= pcr_pkg::PCR_LOAD;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign s_axi_awready  = q.awready;
	assign s_axi_wready   = q.wready;
	assign s_axi_bresp    = q.bresp;
	assign s_axi_bvalid   = q.bvalid;
	assign s_axi_arready  = q.arready;
	assign s_axi_rdata    = q.rdata;
	assign s_axi_rresp    = q.rresp;
	assign s_axi_rvalid   = q.rvalid;
	assign word_data      = q.word_data;
	assign word_valid     = q.word_valid;
	assign work_cycle     = q.work_cycle;
	assign init_clock_sel = q.clk_sel;
	assign user_mode      = q.user_mode;
endmodule

// [bench/pcr_loader_chk.sv]
// Purpose: Pin timing checks for the parallel loader.
// Assumes: Host load clock period is under 16 aclk cycles.
// Notes: Longer gaps between load clock rises are idle time.
`timescale 1ns/100ps
module pcr_loader_chk (
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	config_load_clock,
	input wire logic	load_complete_flag,
	input wire logic	user_init_clock,
	input wire logic	word_valid,
	input wire logic	work_cycle,
	input wire logic	init_clock_sel,
	input wire logic	user_mode
);
	logic [7:0]	per_q;	// Cycles since last load clock rise
	logic [7:0]	max_q;	// Longest load period seen
	logic [23:0]	done_q;	// Cycles with done pin high
	logic [15:0]	urise_q;	// User clock rises since select
	logic [1:0]	pin_q;	// Last user and load clock

	// Measure periods and delays from the pins themselves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_q <= 8'h00;
			max_q <= 8'h00;
			done_q <= 24'h00_0000;
			urise_q <= 16'h0000;
			pin_q <= 2'h0;
		end else begin
			pin_q <= {user_init_clock, config_load_clock};
			done_q <= load_complete_flag ? done_q + 24'h00_0001 : 24'h00_0000;
			// Idle gaps would inflate the bound, so they are skipped
			if (config_load_clock && !pin_q[0]) begin
				per_q <= 8'h01;
				if (per_q != 8'h00 && per_q < 8'h10 && per_q > max_q)
					max_q <= per_q;
			end else if (per_q != 8'h00 && per_q != 8'hff) begin
				per_q <= per_q + 8'h01;
			end
			// Count user clock rises only once selected
			if (!init_clock_sel)
				urise_q <= 16'h0000;
			else if (user_init_clock && !pin_q[1])
				urise_q <= urise_q + 16'h0001;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Switch onto the user clock
	sequence sel_rise;
		$rose(init_clock_sel);
	endsequence

	// User mode reached on the user clock
	sequence mode_rise_user;
		$rose(user_mode) && init_clock_sel;
	endsequence

	pulse_excl_a: assert property (
		!(word_valid && work_cycle)) else $error("sample and work pulse together");
	word_once_a: assert property (
		word_valid |=> !word_valid) else $error("sample pulse longer than one cycle");
	work_once_a: assert property (
		work_cycle |=> !work_cycle) else $error("work pulse longer than one cycle");
	switch_wait_a: assert property (
		sel_rise |-> done_q >= {14'h0000, max_q, 2'h0}) else $error("clock switch too early");
	switch_done_a: assert property (
		sel_rise |-> load_complete_flag) else $error("clock switch without done");
	user_wait_a: assert property (
		mode_rise_user |-> urise_q >= 16'h2180) else $error("user mode too early");
endmodule

// [bench/pcr_host_model.sv]
// Purpose: Host that drives the parallel load pins.
// Assumes: Load clock period 400 ns, user clock 200 ns.
// Notes: Load clock stands low between word periods.
`timescale 1ns/100ps
module pcr_host_model (
	output logic	config_load_clock,
	output logic [31:0]	config_data,
	output logic	load_complete_flag,
	output logic	user_init_clock
);
	logic	run;	// User clock enable

	// Quiet pins at time zero
	initial begin
		config_load_clock = 1'b0;
		config_data = 32'h0000_0000;
		load_complete_flag = 1'b0;
		user_init_clock = 1'b0;
		run = 1'b0;
	end

	// User init clock runs only when asked for
	always #100 user_init_clock = run ? ~user_init_clock : 1'b0;

	// One word period of r clocks; junk on the extra clocks
	task automatic send_word(input logic [31:0] w, input int r);
		for (int k = 0; k < r; k++) begin
			config_data <= (k == 0) ? w : ~w;
			#200 config_load_clock <= 1'b1;
			// Released mid-high: lines must not look like the last word
			#100 config_data <= ~w;
			#100 config_load_clock <= 1'b0;
		end
	endtask

	// Done pin and user clock together
	task automatic set_done(input logic on, input logic uclk);
		load_complete_flag <= on;
		run <= uclk;
	endtask
endmodule

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the parallel loader.
// Assumes: Host model owns the load pins.
// Notes: Checker bound below, outside the module.
`timescale 1ns/100ps
`include "pcr_cfg.svh"
module tb_top;
	logic	aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]	awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]	wdata = 32'h0000_0000;
	logic	awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic	awready, wready, bvalid, arready, rvalid, lclk, done, uclk, wv, wk, sel, um;
	logic [1:0]	bresp, rresp;
	logic [31:0]	rdata, cdata, wdat;
	int	bad_count = 0, check_count = 0, cyc = 0, nwv = 0, nwk = 0;

	pcr_loader i_pcr_loader (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .config_load_clock(lclk),
		.config_data(cdata), .load_complete_flag(done), .user_init_clock(uclk),
		.word_data(wdat), .word_valid(wv), .work_cycle(wk), .init_clock_sel(sel),
		.user_mode(um));
	pcr_host_model i_pcr_host_model (.config_load_clock(lclk), .config_data(cdata),
		.load_complete_flag(done), .user_init_clock(uclk));

	// Clock and pulse counters, read mid-cycle
	always #25 aclk = ~aclk;
	always @(negedge aclk) begin
		nwv += (wv === 1'b1);
		nwk += (wk === 1'b1);
	end
	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	// Write: both channels offered, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic	ta, tw, tb;
		logic [1:0]	rs;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				break;
			end
		end
		chk("bresp", rs, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic	ta, tr;
		logic [31:0]	v;
		logic [1:0]	rs;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
				break;
			end
		end
		chk("rdata", v, d);
		chk("rresp", rs, e);
	endtask

	function automatic int ratio(input int w, input logic dc, input logic sc);
		if (dc) return (w == 0) ? 2 : (w == 1) ? 4 : 8;
		if (sc) return (w == 0) ? 1 : (w == 1) ? 2 : 4;
		return 1;
	endfunction

	// Every width and option pair, two words each
	task automatic t_ratio();
		int	r;
		logic [31:0]	m;
		for (int c = 0; c < 12; c++) begin
			r = ratio(c / 4, c[1], c[0]);
			m = (c < 4) ? 32'h0000_00ff : (c < 8) ? 32'h0000_ffff : 32'hffff_ffff;
			wr(`PCR_OFF_CTRL, 32'(c / 4 + c[1] * 4 + c[0] * 8), `PCR_RESP_OKAY);
			nwv = 0;
			nwk = 0;
			i_pcr_host_model.send_word(32'ha5c3_0f96 ^ c, r);
			i_pcr_host_model.send_word(32'h3c5a_e187 + c, r);
			repeat (6) @(posedge aclk);
			chk("words", nwv, 2);
			chk("work", nwk, 2 * (r - 1));
			chk("word_data", wdat & m, (32'h3c5a_e187 + c) & m);
		end
		rd(`PCR_OFF_CTRL, 32'h0000_000e, `PCR_RESP_OKAY);
		// Last full word and the count of 24 sampled words, then clear
		rd(`PCR_OFF_DATA, 32'h3c5a_e192, `PCR_RESP_OKAY);
		rd(`PCR_OFF_WORDS, 32'h0000_0018, `PCR_RESP_OKAY);
		wr(`PCR_OFF_WORDS, 32'h0000_0000, `PCR_RESP_OKAY);
		rd(`PCR_OFF_WORDS, 32'h0000_0000, `PCR_RESP_OKAY);
		rd(8'h14, 32'h0000_0000, `PCR_RESP_SLVERR);
		wr(`PCR_OFF_STATUS, 32'h0000_00ff, `PCR_RESP_SLVERR);
		$display("t_ratio finished");
	endtask

	// Done rise to user mode, with and without user clock
	task automatic t_init(input logic on);
		int	n;
		wr(`PCR_OFF_CTRL, {27'h000_0000, on, 4'h0}, `PCR_RESP_OKAY);
		// A short load first, so this load has a known longest period
		i_pcr_host_model.send_word(32'h5a0f_c3e1, 1);
		i_pcr_host_model.send_word(32'h1e2d_3c4b, 1);
		i_pcr_host_model.set_done(1'b1, on);
		n = 0;
		while (um !== 1'b1 && n < 40000) begin
			@(negedge aclk);
			n++;
		end
		// Floor: four 8-cycle load periods, plus 8576 user periods of 4 cycles
		chk("delay", n >= (on ? 34336 : 32), 1);
		chk("user_mode", um, 1);
		chk("clock_sel", sel, on);
		rd(`PCR_OFF_STATUS, on ? 32'h0000_0087 : 32'h0000_0085, `PCR_RESP_OKAY);
		i_pcr_host_model.set_done(1'b0, 1'b0);
		repeat (10) @(negedge aclk);
		chk("restart", um, 0);
		$display("t_init finished");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_ratio();
		t_init(1'b1);
		t_init(1'b0);
		conclude();
	end
endmodule

bind pcr_loader pcr_loader_chk i_pcr_loader_chk (.aclk(aclk), .aresetn(aresetn),
	.config_load_clock(config_load_clock), .load_complete_flag(load_complete_flag),
	.user_init_clock(user_init_clock), .word_valid(word_valid),
	.work_cycle(work_cycle), .init_clock_sel(init_clock_sel), .user_mode(user_mode));
